// ### logic/dfc_pkg.sv
// Summary of operation
// RULE1: Host alternates secondary converter; primary runs continuously
// RULE2: Two auxiliary paths start separately; host compares
// RULE3: Open-wire bit enables test currents; pull direction
// RULE4: Channel zero with open-wire drives every GPIO
// RULE5: Two read slaves compared; mismatch sets fault
// RULE6: Error-injection bit exercises the read-mismatch flag
// RULE7: Thermal trip: reset, set flag, discharge off
// RULE8: Thermal flag clears only by clear-flag bit; the code also clears it on soft reset
// RULE9: Config A byte1 bit4 forces thermal flag
// RULE10: Test-mode flag set on factory test entry
// RULE11: Config A byte1 bit7 forces test-mode flag
// RULE12: Sleep flag shows power cycle or sleep
// RULE13: Soft reset forwards down chain, then sleeps
// RULE14: Revision code bits all enter read PEC
// RULE15: Unique 48-bit serial identifier returned on read
// RULE16: Cell, filtered, secondary clears write 0x8000
// RULE17: Auxiliary clear writes 0x8000 to its groups
// RULE18: Result clears act only in reference-up, measure
// RULE19: Host sends six payload bytes after clear-flag
// RULE20: Payload bit one clears same status-C bit
// RULE21: Flags stay set until cleared or sleep
// RULE22: Cell redundancy fault on over-threshold difference
// RULE23: Payload bytes 2,3 and undefined bits ignored
package dfc_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [10:0] CMD_WR_CFG_A = 11'h001;
    localparam logic [10:0] CMD_CLR_FLAGS = 11'h017;
    localparam logic [10:0] CMD_SOFT_RESET = 11'h027;
    localparam logic [10:0] CMD_RD_SERIAL = 11'h02c;
    localparam logic [10:0] CMD_RD_STAT_C = 11'h030;
    localparam logic [10:0] CMD_RD_REV = 11'h032;
    localparam logic [10:0] CMD_CLR_CELL = 11'h711;
    localparam logic [10:0] CMD_CLR_AUX = 11'h712;
    localparam logic [10:0] CMD_CLR_FILT = 11'h714;
    localparam logic [10:0] CMD_CLR_SEC = 11'h716;
    localparam logic [10:0] AUX_MASK = 11'h630;
    localparam logic [10:0] AUX_MATCH = 11'h410;
    localparam logic [10:0] SECOND_AUX_MASK = 11'h7f0;
    localparam logic [10:0] SECOND_AUX_MATCH = 11'h400;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ERR_BIT = 6;
    localparam int OPEN_WIRE_BIT = 8;
    localparam int PULL_DIR_BIT = 7;
    localparam int CH4_BIT = 6;
    localparam int FORCE_THERMAL_BIT = 4;
    localparam int FORCE_TEST_BIT = 7;
    localparam int S5_SUPPLY_LATCH = 7;
    localparam int S5_SUPPLY_ERR = 6;
    localparam int S5_READ_FAULT = 4;
    localparam int S5_SLEEP = 3;
    localparam int S5_THERMAL = 2;
    localparam int S5_TEST = 1;
    localparam int S5_OSC = 0;
    localparam logic [7:0] S5_DEFINED = 8'hdf;
    localparam logic [7:0] S5_RESET = 8'h08;
    // ------------------------------------------------------------
    // Sizes and values
    // ------------------------------------------------------------
    localparam int GROUP_BYTES = 6;
    localparam int FRAME_BYTES = 8;
    localparam int NUM_GPIO = 10;
    localparam logic [15:0] RESULT_CLEAR_WORD = 16'h8000;
    localparam logic [9:0] PEC_POLY = 10'h08f;
    localparam logic [9:0] PEC_SEED = 10'h010;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_REF_UP = 2'b01,
        MODE_MEASURE = 2'b10,
        MODE_OTHER = 2'b11
    } dfc_mode_e;

    // ------------------------------------------------------------
    // Shared functions
    // ------------------------------------------------------------
    function automatic logic [9:0] pec_byte(input logic [9:0] crc,
                                            input logic [7:0] b);
        logic [9:0] c;
        logic fb;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            fb = c[9] ^ b[i];
            c = {c[8:0], 1'b0};
            if (fb) begin
                c = c ^ PEC_POLY;
            end
        end
        return c;
    endfunction

    function automatic logic is_stat_c(input logic [10:0] cmd);
        logic [10:0] m;
        m = cmd;
        m[ERR_BIT] = 1'b0;
        return m == CMD_RD_STAT_C;
    endfunction

    function automatic logic has_payload(input logic [10:0] cmd);
        return cmd == CMD_CLR_FLAGS || cmd == CMD_WR_CFG_A;
    endfunction

    function automatic logic is_read(input logic [10:0] cmd);
        return is_stat_c(cmd) || cmd == CMD_RD_SERIAL ||
            cmd == CMD_RD_REV;
    endfunction
endpackage

// ### logic/dfc_link_if.sv
`timescale 1ns/1ps
interface dfc_link_if (
    input wire logic sys_clk
);
    logic cmdValid;
    logic [10:0] cmdCode;
    logic wrValid;
    logic [7:0] wrByte;
    logic rdValid;
    logic [7:0] rdByte;
    logic devBusy;

    modport device (
        input sys_clk, cmdValid, cmdCode, wrValid, wrByte,
        output rdValid, rdByte, devBusy
    );
    modport host (
        input sys_clk, rdValid, rdByte, devBusy,
        output cmdValid, cmdCode, wrValid, wrByte
    );
endinterface

// ### logic/dfc_device.sv
`timescale 1ns/1ps
module dfc_device
    import dfc_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h3,          // Arbitrary value
    parameter logic [47:0] SERIAL_ID = 48'h5a5a_0123_4567 // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst,
    dfc_link_if.device link,
    input wire dfc_mode_e opMode,
    input wire logic thermalTrip,
    input wire logic testModeEntry,
    input wire logic wake,
    input wire logic redundantDone,
    input wire logic [15:0] cellOverThresh,
    input wire logic [7:0] supplyEvents,
    input wire logic [2:0] miscEvents,
    output logic porReq,
    output logic dischargeOff,
    output logic sleepState,
    output logic chainForward,
    output logic auxStart,
    output logic secondAuxStart,
    output logic [4:0] auxChannel,
    output logic [NUM_GPIO-1:0] openWireEn,
    output logic pullUpSel,
    output logic clear_cell_results_cmd,
    output logic clrFilt,
    output logic clear_auxiliary_results_cmd,
    output logic clrSec,
    output logic [15:0] resultClearWord,
    output logic [47:0] statusC
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WDATA = 3'b001,
        S_RDATA = 3'b010,
        S_FWD = 3'b011,
        S_SLEEP = 3'b100
    } dfc_state_e;

    dfc_state_e state;
    logic [10:0] pendCmd;
    logic [47:0] wrBuf;
    logic [47:0] rdBuf;
    logic [2:0] cnt;
    logic [9:0] pec;
    logic [15:0] csFlag;
    logic [7:0] supFlag;
    logic [7:0] s5Flag;
    logic cmdSeen;
    logic payloadDone;
    logic clrFire;
    logic cfgFire;
    logic wipe;
    logic mismatch;
    logic [47:0] next_wrBuf;
    logic [47:0] slaveA;
    logic [47:0] slaveB;
    logic [7:0] set5;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic [47:0] read_mux(input logic [10:0] cmd,
                                             input logic [47:0] stc);
        if (cmd == CMD_RD_SERIAL) begin
            return SERIAL_ID; // RULE15
        end else if (cmd == CMD_RD_REV) begin
            return {44'h0, REVISION}; // RULE14
        end else begin
            return stc;
        end
    endfunction

    function automatic logic [NUM_GPIO-1:0] gpio_sel(input logic [4:0] ch);
        logic [NUM_GPIO-1:0] m;
        m = '0;
        if (ch == 5'h00) begin
            m = '1; // RULE4
        end else if (ch <= 5'(NUM_GPIO)) begin
            m[ch[3:0] - 4'h1] = 1'b1;
        end
        return m;
    endfunction

    assign cmdSeen = link.cmdValid && state == S_IDLE;
    assign next_wrBuf = {link.wrByte, wrBuf[47:8]};
    assign payloadDone = state == S_WDATA && link.wrValid &&
        cnt == 3'(GROUP_BYTES - 1);
    assign clrFire = payloadDone && pendCmd == CMD_CLR_FLAGS;
    assign cfgFire = payloadDone && pendCmd == CMD_WR_CFG_A;
    assign wipe = thermalTrip || (state == S_FWD);
    assign link.devBusy = state != S_IDLE;
    assign statusC = {s5Flag, supFlag, 16'h0000, csFlag};

    // Two independent read paths; the second may carry an injected error
    assign slaveA = read_mux(link.cmdCode, statusC); // RULE5
    assign slaveB = read_mux(link.cmdCode, statusC) ^
        {47'h0, is_stat_c(link.cmdCode) && link.cmdCode[ERR_BIT]}; // RULE6
    assign mismatch = cmdSeen && is_read(link.cmdCode) &&
        slaveA != slaveB; // RULE5

    // ------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= S_IDLE;
            cnt <= 3'h0;
            pendCmd <= 11'h000;
        end else if (thermalTrip) begin
            state <= S_IDLE; // RULE7
            cnt <= 3'h0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    cnt <= 3'h0;
                    if (link.cmdValid) begin
                        pendCmd <= link.cmdCode;
                        if (has_payload(link.cmdCode)) begin
                            state <= S_WDATA; // RULE19
                        end else if (is_read(link.cmdCode)) begin
                            state <= S_RDATA;
                        end else if (link.cmdCode == CMD_SOFT_RESET) begin
                            state <= S_FWD; // RULE13
                        end
                    end
                end
                S_WDATA: begin
                    if (link.wrValid) begin
                        cnt <= cnt + 3'h1;
                        if (payloadDone) begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_RDATA: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'(FRAME_BYTES - 1)) begin
                        state <= S_IDLE;
                    end
                end
                S_FWD: state <= S_SLEEP; // RULE13
                S_SLEEP: begin
                    if (wake) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrBuf <= 48'h0;
        end else if (state == S_WDATA && link.wrValid) begin
            wrBuf <= next_wrBuf;
        end
    end

    // ------------------------------------------------------------
    // Read frame with PEC over every data bit
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdBuf <= 48'h0;
            pec <= PEC_SEED;
            link.rdValid <= 1'b0;
            link.rdByte <= 8'h00;
        end else begin
            link.rdValid <= state == S_RDATA;
            if (cmdSeen && is_read(link.cmdCode)) begin
                rdBuf <= slaveA;
                pec <= PEC_SEED;
            end else if (state == S_RDATA) begin
                if (cnt < 3'(GROUP_BYTES)) begin
                    link.rdByte <= rdBuf[7:0];
                    rdBuf <= {8'h00, rdBuf[47:8]};
                    pec <= pec_byte(pec, rdBuf[7:0]); // RULE14
                end else if (cnt == 3'(GROUP_BYTES)) begin
                    link.rdByte <= {6'h00, pec[9:8]};
                end else begin
                    link.rdByte <= pec[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Diagnostic flags
    // ------------------------------------------------------------
    always_comb begin
        set5 = 8'h00;
        set5[S5_SUPPLY_LATCH] = miscEvents[2];
        set5[S5_SUPPLY_ERR] = miscEvents[1];
        set5[S5_OSC] = miscEvents[0];
        set5[S5_READ_FAULT] = mismatch; // RULE5
        set5[S5_TEST] = testModeEntry ||
            (cfgFire && next_wrBuf[8 + FORCE_TEST_BIT]); // RULE10 RULE11
        set5[S5_THERMAL] = cfgFire &&
            next_wrBuf[8 + FORCE_THERMAL_BIT]; // RULE9
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            csFlag <= 16'h0000;
            supFlag <= 8'h00;
            s5Flag <= S5_RESET; // RULE12
        end else if (wipe) begin
            csFlag <= 16'h0000; // RULE21
            supFlag <= 8'h00;
            s5Flag <= S5_RESET |
                (8'(thermalTrip) << S5_THERMAL); // RULE7 RULE12
        end else begin
            // Set wins over a clear in the same cycle
            csFlag <= (csFlag & ~({16{clrFire}} & next_wrBuf[15:0])) |
                ({16{redundantDone}} & cellOverThresh); // RULE20 RULE22
            supFlag <= (supFlag & ~({8{clrFire}} & next_wrBuf[39:32])) |
                supplyEvents; // RULE20 RULE23
            s5Flag <= (s5Flag &
                ~({8{clrFire}} & next_wrBuf[47:40] & S5_DEFINED)) |
                set5; // RULE8 RULE23
        end
    end

    // ------------------------------------------------------------
    // Power, sleep and chain outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            porReq <= 1'b0;
            dischargeOff <= 1'b1;
            sleepState <= 1'b0;
            chainForward <= 1'b0;
        end else begin
            porReq <= thermalTrip; // RULE7
            dischargeOff <= thermalTrip || state == S_FWD ||
                state == S_SLEEP; // RULE7
            sleepState <= state == S_FWD ||
                (state == S_SLEEP && !wake);
            chainForward <= cmdSeen &&
                link.cmdCode == CMD_SOFT_RESET; // RULE13
        end
    end

    // ------------------------------------------------------------
    // Auxiliary conversion starts
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || wipe) begin
            auxStart <= 1'b0;
            secondAuxStart <= 1'b0;
            auxChannel <= 5'h00;
            openWireEn <= '0;
            pullUpSel <= 1'b0;
        end else begin
            auxStart <= 1'b0;
            secondAuxStart <= 1'b0;
            if (cmdSeen && (link.cmdCode & AUX_MASK) == AUX_MATCH) begin
                auxStart <= 1'b1; // RULE2
                auxChannel <= {link.cmdCode[CH4_BIT], link.cmdCode[3:0]};
                pullUpSel <= link.cmdCode[PULL_DIR_BIT]; // RULE3
                openWireEn <= link.cmdCode[OPEN_WIRE_BIT] &&
                    !link.cmdCode[CH4_BIT] ?
                    gpio_sel({1'b0, link.cmdCode[3:0]}) : '0; // RULE3 RULE4
            end else if (cmdSeen &&
                (link.cmdCode & SECOND_AUX_MASK) == SECOND_AUX_MATCH) begin
                secondAuxStart <= 1'b1; // RULE2
                auxChannel <= {1'b0, link.cmdCode[3:0]};
                openWireEn <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Result memory clears
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clear_cell_results_cmd <= 1'b0;
            clrFilt <= 1'b0;
            clear_auxiliary_results_cmd <= 1'b0;
            clrSec <= 1'b0;
            resultClearWord <= RESULT_CLEAR_WORD;
        end else begin
            resultClearWord <= RESULT_CLEAR_WORD; // RULE16 RULE17
            clear_cell_results_cmd <= cmdSeen && link.cmdCode == CMD_CLR_CELL &&
                (opMode == MODE_REF_UP || opMode == MODE_MEASURE); // RULE18
            clrFilt <= cmdSeen && link.cmdCode == CMD_CLR_FILT &&
                (opMode == MODE_REF_UP || opMode == MODE_MEASURE); // RULE18
            clear_auxiliary_results_cmd <= cmdSeen && link.cmdCode == CMD_CLR_AUX &&
                (opMode == MODE_REF_UP || opMode == MODE_MEASURE); // RULE17
            clrSec <= cmdSeen && link.cmdCode == CMD_CLR_SEC &&
                (opMode == MODE_REF_UP || opMode == MODE_MEASURE); // RULE16
        end
    end
endmodule

// ### logic/dfc_host.sv
`timescale 1ns/1ps
module dfc_host
    import dfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    dfc_link_if.host link,
    input wire logic reqValid,
    input wire logic [10:0] reqCmd,
    input wire logic [47:0] reqData,
    output logic reqReady,
    output logic respValid,
    output logic [47:0] respData,
    output logic respPecOk
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_WR = 2'b01,
        H_RD = 2'b10
    } dfc_hstate_e;

    dfc_hstate_e state;
    logic [47:0] buffer;
    logic [2:0] cnt;
    logic [9:0] pec;
    logic [7:0] pecHigh;

    assign reqReady = state == H_IDLE && !link.devBusy;

    // ------------------------------------------------------------
    // Command and payload
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= H_IDLE;
            buffer <= 48'h0;
            cnt <= 3'h0;
            link.cmdValid <= 1'b0;
            link.cmdCode <= 11'h000;
            link.wrValid <= 1'b0;
            link.wrByte <= 8'h00;
        end else begin
            link.cmdValid <= 1'b0;
            link.wrValid <= 1'b0;
            unique case (state)
                H_IDLE: begin
                    cnt <= 3'h0;
                    if (reqValid && reqReady) begin
                        link.cmdValid <= 1'b1;
                        link.cmdCode <= reqCmd;
                        buffer <= reqData;
                        if (has_payload(reqCmd)) begin
                            state <= H_WR; // RULE19
                        end else if (is_read(reqCmd)) begin
                            state <= H_RD;
                        end
                    end
                end
                H_WR: begin
                    link.wrValid <= 1'b1; // RULE19
                    link.wrByte <= buffer[7:0];
                    buffer <= {8'h00, buffer[47:8]};
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'(GROUP_BYTES - 1)) begin
                        state <= H_IDLE;
                    end
                end
                H_RD: begin
                    if (link.rdValid) begin
                        cnt <= cnt + 3'h1;
                        if (cnt < 3'(GROUP_BYTES)) begin
                            buffer <= {link.rdByte, buffer[47:8]};
                        end
                        if (cnt == 3'(FRAME_BYTES - 1)) begin
                            state <= H_IDLE;
                        end
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read answer and PEC check
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pec <= PEC_SEED;
            pecHigh <= 8'h00;
            respValid <= 1'b0;
            respData <= 48'h0;
            respPecOk <= 1'b0;
        end else begin
            respValid <= 1'b0;
            if (state == H_IDLE) begin
                pec <= PEC_SEED;
            end else if (state == H_RD && link.rdValid) begin
                if (cnt < 3'(GROUP_BYTES)) begin
                    pec <= pec_byte(pec, link.rdByte); // RULE14
                end else if (cnt == 3'(GROUP_BYTES)) begin
                    pecHigh <= link.rdByte;
                end else begin
                    respValid <= 1'b1;
                    respData <= buffer;
                    respPecOk <= {pecHigh[1:0], link.rdByte} == pec;
                end
            end
        end
    end
endmodule

// ### testbench/dfc_props.sv
`timescale 1ns/1ps
module dfc_props
    import dfc_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h3,
    parameter logic [47:0] SERIAL_ID = 48'h0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmdValid,
    input wire logic [10:0] cmdCode,
    input wire logic wrValid,
    input wire logic [7:0] wrByte,
    input wire logic rdValid,
    input wire logic [7:0] rdByte,
    input wire logic devBusy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire take = cmdValid && !devBusy;
    wire rdCmd = take && (cmdCode == CMD_RD_STAT_C || cmdCode == 11'h070
        || cmdCode == CMD_RD_SERIAL || cmdCode == CMD_RD_REV);

    a_read_burst: assert property (rdCmd
        |-> ##2 rdValid [*8] ##1 !rdValid)
        else $error("read burst length wrong");
    a_pec_high: assert property (rdCmd |-> ##8 rdByte[7:2] == 6'h00)
        else $error("check byte high bits not zero");
    a_rev_code: assert property (take && cmdCode == CMD_RD_REV
        |-> ##2 rdByte[3:0] == REVISION) else $error("revision wrong");
    a_serial_id: assert property (take && cmdCode == CMD_RD_SERIAL
        |-> ##2 rdByte == SERIAL_ID[7:0] ##5 rdByte == SERIAL_ID[47:40])
        else $error("serial id wrong");
    a_clr_payload: assert property (take && cmdCode == CMD_CLR_FLAGS
        |-> ##1 (devBusy && wrValid) [*6] ##1 !devBusy)
        else $error("clear payload framing wrong");
    a_rd_in_busy: assert property ($rose(rdValid)
        |-> devBusy [*7] ##1 !devBusy) else $error("read byte while idle");
    a_wr_in_busy: assert property (wrValid |-> devBusy)
        else $error("payload byte while idle");
    a_soft_reset_cmd_busy: assert property (take && cmdCode == CMD_SOFT_RESET
        |-> ##1 devBusy) else $error("soft reset not taken");

    cover property (rdCmd);
    cover property (take && cmdCode == CMD_CLR_FLAGS);
    cover property (take && cmdCode == CMD_SOFT_RESET);
endmodule

// ### testbench/tb_diagnostic_flags_and_clears.sv
`timescale 1ns/1ps
module tb_diagnostic_flags_and_clears
    import dfc_pkg::*;
;
    localparam logic [3:0] T_REV = 4'h9; // Arbitrary value
    localparam logic [47:0] T_SERIAL = 48'h1357_9bdf_2468; // Arbitrary value
    logic sysClk = 0, rst = 1, reqValid = 0, thermalTrip = 0;
    logic testModeEntry = 0, wake = 0, redundantDone = 0;
    dfc_mode_e opMode = MODE_STANDBY;
    logic [10:0] reqCmd = '0;
    logic [10:0] codes [4] = '{CMD_CLR_CELL, CMD_CLR_AUX, CMD_CLR_FILT,
        CMD_CLR_SEC};
    logic [47:0] reqData = '0, rdat;
    logic [15:0] cellOverThresh = '0;
    logic [7:0] supplyEvents = '0;
    logic [2:0] miscEvents = '0;
    wire reqReady, respValid, respPecOk, porReq, dischargeOff, sleepState;
    wire chainForward, auxStart, secondAuxStart, pullUpSel;
    wire clear_cell_results_cmd, clrFilt, clear_auxiliary_results_cmd, clrSec;
    wire [47:0] respData, statusC;
    wire [4:0] auxChannel;
    wire [9:0] openWireEn;
    wire [15:0] resultClearWord;
    int failures = 0, nTests = 0, cyc = 0;

    dfc_link_if link (.sys_clk(sysClk));
    dfc_device #(.REVISION(T_REV), .SERIAL_ID(T_SERIAL)) i_dfc_device (
        .sys_clk(sysClk), .rst, .link(link.device), .opMode, .thermalTrip,
        .testModeEntry, .wake, .redundantDone, .cellOverThresh,
        .supplyEvents, .miscEvents, .porReq, .dischargeOff, .sleepState,
        .chainForward, .auxStart, .secondAuxStart, .auxChannel,
        .openWireEn, .pullUpSel, .clear_cell_results_cmd, .clrFilt, .clear_auxiliary_results_cmd, .clrSec,
        .resultClearWord,
        .statusC);
    dfc_host i_dfc_host (.sys_clk(sysClk), .rst, .link(link.host),
        .reqValid, .reqCmd, .reqData, .reqReady, .respValid, .respData,
        .respPecOk);
    dfc_props #(.REVISION(T_REV), .SERIAL_ID(T_SERIAL)) i_dfc_props (
        .sys_clk(sysClk), .rst, .cmdValid(link.cmdValid),
        .cmdCode(link.cmdCode), .wrValid(link.wrValid),
        .wrByte(link.wrByte), .rdValid(link.rdValid),
        .rdByte(link.rdByte), .devBusy(link.devBusy));

    initial begin
        forever #4 sysClk = ~sysClk;
    end
    always @(posedge sysClk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Host-side helpers
    // ------------------------------------------------------------
    task chk(input logic [47:0] got, input logic [47:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge sysClk);
        #1;
    endtask
    // Returns one cycle after the command appears on the link
    task send(input logic [10:0] c, input logic [47:0] d);
        reqCmd = c;
        reqData = d;
        reqValid = 1;
        while (reqReady !== 1'b1) step(1);
        step(1);
        reqValid = 0;
        while (link.cmdValid !== 1'b1) step(1);
        step(1);
    endtask
    task idle;
        while (reqReady !== 1'b1) step(1);
    endtask
    task rd(input logic [10:0] c);
        send(c, '0);
        while (respValid !== 1'b1) step(1);
        rdat = respData;
        chk(48'(respPecOk), 48'h1);
    endtask
    task test_done;
        $display("failures %0d tests %0d", failures, nTests);
        if (failures == 0 && nTests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task s_force;
        rd(CMD_RD_STAT_C);
        chk(rdat, 48'h0800_0000_0000);
        send(CMD_WR_CFG_A, 48'h9000);
        idle;
        chk(statusC, 48'h0e00_0000_0000);
        send(CMD_CLR_FLAGS, 48'h0400_0000_0000);
        idle;
        chk(statusC, 48'h0a00_0000_0000);
        send(CMD_CLR_FLAGS, 48'h0a00_0000_0000);
        idle;
        chk(statusC, '0);
    endtask
    task s_events;
        {testModeEntry, redundantDone, supplyEvents} = {2'b11, 8'hff};
        {miscEvents, cellOverThresh} = {3'h7, 16'ha5c3};
        step(1);
        {testModeEntry, redundantDone, supplyEvents, miscEvents} = '0;
        step(1);
        chk(statusC, 48'hc3ff_0000_a5c3);
        send(CMD_CLR_FLAGS, 48'h2000_ffff_0000);
        idle;
        chk(statusC, 48'hc3ff_0000_a5c3);
        send(CMD_CLR_FLAGS, 48'hc3ff_0000_ffff);
        idle;
        chk(statusC, '0);
    endtask
    task s_ids;
        rd(11'h070);
        chk(statusC, 48'h1000_0000_0000);
        rd(CMD_RD_REV);
        chk(48'(rdat[3:0]), 48'(T_REV));
        rd(CMD_RD_SERIAL);
        chk(rdat, T_SERIAL);
        send(11'h590, '0);
        chk(48'({auxStart, secondAuxStart, pullUpSel, openWireEn}),
            48'h17ff);
        send(11'h405, '0);
        chk(48'({auxStart, secondAuxStart, auxChannel}), 48'h25);
    endtask
    task s_clears;
        for (int m = 0; m < 4; m++) begin
            opMode = dfc_mode_e'(m);
            for (int k = 0; k < 4; k++) begin
                send(codes[k], '0);
                chk(48'({clear_cell_results_cmd, clear_auxiliary_results_cmd, clrFilt, clrSec, resultClearWord}),
                    48'({(m == 1 || m == 2) ? 4'b1000 >> k : 4'h0,
                    16'h8000}));
            end
        end
        opMode = MODE_STANDBY;
    endtask
    task s_sleep;
        chk(48'({porReq, dischargeOff}), 48'h0);
        thermalTrip = 1;
        step(1);
        thermalTrip = 0;
        chk(statusC, 48'h0c00_0000_0000);
        chk(48'({porReq, dischargeOff}), 48'h3);
        wake = 1;
        step(1);
        wake = 0;
        step(1);
        send(CMD_SOFT_RESET, '0);
        chk(48'(chainForward), 48'h1);
        step(1);
        chk(48'(sleepState), 48'h1);
        wake = 1;
        step(1);
        wake = 0;
        step(1);
        rd(CMD_RD_STAT_C);
        chk(rdat, 48'h0800_0000_0000);
    endtask

    initial begin
        repeat (16) @(posedge sysClk);
        #1 rst = 0;
        step(1);
        s_force();
        s_events();
        s_ids();
        s_clears();
        s_sleep();
        test_done();
    end
endmodule
